// *** bench/sci_host.sv ***
`timescale 1ns/10ps
// ==========================================================
// Host side: software reaching the registers over the plain port.
module sci_host (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    output logic      [7:0]  o_addr,
    output logic      [15:0] o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    // Bus idles with both strobes low until software acts.
    initial begin
        o_addr = 8'h00;
        o_wdata = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // One-cycle write strobe beside address and data.
    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask : bus_wr
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask : bus_rd
endmodule : sci_host

// *** bench/sci_supply_change_irq_test.sv ***
`timescale 1ns/10ps
module sci_supply_change_irq_test;
    logic                 clk;
    logic                 rst_n;
    sci_pkg::sci_supply_t sup;
    logic [7:0]           addr;
    logic [15:0]          wdata;
    logic [15:0]          rdata;
    logic [15:0]          v;
    logic                 wr;
    logic                 rd;
    logic                 irq;
    int                   error_cnt = 0;
    int                   n_checks = 0;
    sci_supply_change_irq dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
        .i_usb_supply_present(sup.usb), .i_wall_supply_present(sup.wall),
        .i_battery_supply_present(sup.batt), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_supply_change_irq(irq));
    sci_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    // ==========================================================
    // Clock, checks and the single closing point.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // Toggle one presence line and allow the synchroniser to settle.
    task automatic flip(input int b);
        @(posedge clk);
        sup[b] <= ~sup[b];
        repeat (5) @(posedge clk);
        #1;
    endtask : flip
    // ==========================================================
    // Scenarios.
    task automatic t_reset;
        host.bus_rd(sci_pkg::MASK_OFFSET, v);
        chk("mask", 16'h0000, v);
        chk("irq", 16'h0000, {15'h0000, irq});
    endtask : t_reset
    // Each line rises then falls; both edges must flag and clear on read.
    task automatic t_edges;
        for (int k = 0; k < 6; k++) begin
            flip(k % 3);
            chk("irq", 16'h0001, {15'h0000, irq});
            host.bus_rd(sci_pkg::STATUS_OFFSET, v);
            chk("status", 16'h2000 << (k % 3), v);
            host.bus_rd(sci_pkg::STATUS_OFFSET, v);
            chk("status", 16'h0000, v);
            chk("irq", 16'h0000, {15'h0000, irq});
        end
    endtask : t_edges
    task automatic t_mask;
        host.bus_wr(sci_pkg::MASK_OFFSET, 16'h4000);
        flip(1);
        chk("irq", 16'h0000, {15'h0000, irq});
        host.bus_rd(sci_pkg::MASK_OFFSET, v);
        chk("mask", 16'h4000, v);
        // Unmasking a pending flag must raise the interrupt at once.
        host.bus_wr(sci_pkg::MASK_OFFSET, 16'h0000);
        @(posedge clk);
        #1;
        chk("irq", 16'h0001, {15'h0000, irq});
        host.bus_rd(sci_pkg::STATUS_OFFSET, v);
        chk("status", 16'h4000, v);
    endtask : t_mask
    // Reset for three cycles, then run every scenario.
    initial begin
        sup = 3'h0;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_edges();
        t_mask();
        complete_run();
    end
    // Watchdog well beyond the hundred or so cycles the scenarios need.
    initial begin
        #20000;
        error_cnt++;
        complete_run();
    end
endmodule : sci_supply_change_irq_test

// *** pkg/sci_pkg.sv ***
// Functional notes
// - One first-level supply interrupt formed from exactly three change events.
// - USB, wall and battery presence indicators trigger the change events.
// - A change flag sets on both rising and falling presence edges.
// - Status word: USB flag bit 15, wall bit 14, battery bit 13.
// - A set flag holds until software reads status; the read clears it.
// - Mask bits 15 to 13 match flag positions; set mask blocks that flag.
// - Mask 1 blocks, 0 passes; masks reset to 0.
package sci_pkg;

    // ==========================================================
    // Register map and field layout.
    localparam logic [7:0]  STATUS_OFFSET = 8'h1f;
    localparam logic [7:0]  MASK_OFFSET   = 8'h27;
    localparam int          USB_BIT       = 15;
    localparam int          WALL_BIT      = 14;
    localparam int          BATT_BIT      = 13;
    localparam logic [2:0]  MASK_RESET    = 3'h0;
    localparam logic [2:0]  FLAG_RESET    = 3'h0;

    // ==========================================================
    // Presence indicators travel together, usb in bit 2.
    typedef struct packed {
        logic usb;
        logic wall;
        logic batt;
    } sci_supply_t;

endpackage : sci_pkg

// *** src/sci_supply_change_irq.sv ***
`timescale 1ns/10ps
module sci_supply_change_irq (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic        i_usb_supply_present,
    input  wire logic        i_wall_supply_present,
    input  wire logic        i_battery_supply_present,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    output logic             o_supply_change_irq
);

    // ==========================================================
    // Presence synchronisers and edge history.
    sci_pkg::sci_supply_t meta_r, sync_r, last_r;
    sci_pkg::sci_supply_t pres_raw;
    logic [2:0] flag_r, flag_nxt, mask_r, mask_nxt, chg;
    logic [15:0] rdata_nxt;
    logic        irq_nxt;
    logic        primed_r;

    assign pres_raw = '{usb:  i_usb_supply_present,
                        wall: i_wall_supply_present,
                        batt: i_battery_supply_present};

    // Two flops per pin; the first is read only by the second.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_r   <= '0;
            sync_r   <= '0;
            last_r   <= '0;
            primed_r <= 1'b0;
        end else if (i_ce) begin
            meta_r   <= pres_raw;
            sync_r   <= meta_r;
            last_r   <= sync_r;
            primed_r <= 1'b1;
        end
    end

    // Both edges count; only the first cycle after reset is ignored, so
    // supplies already present at power-up still raise an event once they reach sync_r.
    assign chg = primed_r ? (sync_r ^ last_r) : 3'h0;

    // ==========================================================
    // Flags, masks, read data and interrupt.
    // Map the three flags into their status word positions.
    function automatic logic [15:0] place(input logic [2:0] v);
        logic [15:0] w;
        w = 16'h0000;
        w[sci_pkg::USB_BIT]  = v[2];
        w[sci_pkg::WALL_BIT] = v[1];
        w[sci_pkg::BATT_BIT] = v[0];
        return w;
    endfunction : place

    // A new edge in the read cycle survives, so no event is lost.
    always_comb begin
        flag_nxt  = flag_r;
        mask_nxt  = mask_r;
        rdata_nxt = 16'h0000;
        if (i_rd && i_addr == sci_pkg::STATUS_OFFSET) begin
            rdata_nxt = place(flag_r);
            flag_nxt  = 3'h0;
        end else if (i_rd && i_addr == sci_pkg::MASK_OFFSET) begin
            rdata_nxt = place(mask_r);
        end
        if (i_wr && i_addr == sci_pkg::MASK_OFFSET) begin
            mask_nxt = {i_wdata[sci_pkg::USB_BIT],
                        i_wdata[sci_pkg::WALL_BIT],
                        i_wdata[sci_pkg::BATT_BIT]};
        end
        flag_nxt = flag_nxt | chg;
        irq_nxt  = |(flag_nxt & ~mask_nxt);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            flag_r              <= sci_pkg::FLAG_RESET;
            mask_r              <= sci_pkg::MASK_RESET;
            o_rdata             <= 16'h0000;
            o_supply_change_irq <= 1'b0;
        end else if (i_ce) begin
            flag_r              <= flag_nxt;
            mask_r              <= mask_nxt;
            o_rdata             <= rdata_nxt;
            o_supply_change_irq <= irq_nxt;
        end
    end

    // ==========================================================
    // Checks.
    // The interrupt must always be the registered image of the flags and
    // masks; any skew here would let the host miss or double-count events.
    a_irq_matches: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_supply_change_irq == |(flag_r & ~mask_r))
        else $error("irq does not match unmasked flags");
    // Every detected edge on any of the three lines must leave its flag set.
    a_edge_sets: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && chg[2] |=> flag_r[2])
        else $error("usb edge did not set flag");
    a_wall_edge: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && chg[1] |=> flag_r[1])
        else $error("wall edge did not set flag");
    a_batt_edge: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && chg[0] |=> flag_r[0])
        else $error("battery edge did not set flag");
    // A read with no competing edge empties the status word.
    a_read_clears: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_rd && i_addr == sci_pkg::STATUS_OFFSET && chg == 3'h0
        |=> flag_r == 3'h0)
        else $error("status read did not clear flags");
    // Without a status read no flag may fall.
    a_flag_holds: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && !(i_rd && i_addr == sci_pkg::STATUS_OFFSET)
        |=> (flag_r & $past(flag_r)) == $past(flag_r))
        else $error("flag dropped without read");
    // Status word shows the flags in the top three bits, zeros elsewhere.
    a_status_layout: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_rd && i_addr == sci_pkg::STATUS_OFFSET
        |=> o_rdata[15:13] == $past(flag_r) && o_rdata[12:0] == 13'h0000)
        else $error("status word layout wrong");
    a_mask_write: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_wr && i_addr == sci_pkg::MASK_OFFSET
        |=> mask_r == $past(i_wdata[15:13]))
        else $error("mask write not stored");
    a_masked_quiet: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        mask_r == 3'h7 ##1 mask_r == 3'h7 |-> !o_supply_change_irq)
        else $error("irq with all masked");
    a_mask_reset: assert property (
        @(posedge i_clk)
        !i_rst_n |=> mask_r == 3'h0)
        else $error("mask not cleared by reset");
    // The synchronised sample trails the pins by exactly two enabled edges.
    a_sync_path: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce ##1 i_ce ##1 i_ce |-> sync_r == $past(pres_raw, 2))
        else $error("presence sync broken");

    c_usb_irq: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        chg[2] ##1 o_supply_change_irq);
    c_batt_fall: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        last_r.batt && !sync_r.batt);
    c_read_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_supply_change_irq ##1 !o_supply_change_irq);
    c_masked: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        flag_r != 3'h0 && !o_supply_change_irq);

endmodule : sci_supply_change_irq
